// ==== rtl/sbac_pkg.sv ====
package sbac_pkg;

  // Array geometry
  localparam int BA_W = 2;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTES = 4;
  localparam int BANKS = 4;
  localparam int ADDR_W = BA_W + ROW_W + COL_W;
  localparam int MEM_WORDS = 1 << ADDR_W;
  localparam int BLEN_W = COL_W + 1;
  localparam int REF_W = 12;

  // Read data buffer and latency pipe
  localparam int FIFO_DEPTH = 16;
  localparam int LAT_STAGES = 3;

  // Command pattern on {ras_n, cas_n, we_n}
  localparam logic [2:0] PAT_MODE = 3'h0;
  localparam logic [2:0] PAT_REF = 3'h1;
  localparam logic [2:0] PAT_PRE = 3'h2;
  localparam logic [2:0] PAT_ACT = 3'h3;
  localparam logic [2:0] PAT_WR = 3'h4;
  localparam logic [2:0] PAT_RD = 3'h5;
  localparam logic [2:0] PAT_TERM = 3'h6;

  // Address-line fields
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WB_BIT = 9;

  // Burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  // Latency codes
  localparam logic [2:0] CL_1 = 3'h1;
  localparam logic [2:0] CL_2 = 3'h2;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MODE, CMD_ACT, CMD_READ,
    CMD_WRITE, CMD_PRE, CMD_TERM, CMD_REF
  } sbac_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ROW_W-1:0] addr;
  } sbac_pins_t;

  typedef struct packed {
    logic [2:0] burst_length_setting;
    logic interleaved;
    logic [2:0] cl;
    logic single_write;
  } sbac_mode_t;

  localparam sbac_mode_t MODE_RESET = '{BL_1, 1'b0, CL_2, 1'b0};

  typedef struct packed {
    logic act;
    logic wr;
    logic ap;
    logic [BA_W-1:0] ba;
    logic [COL_W-1:0] start;
    logic [BLEN_W-1:0] idx;
  } sbac_burst_t;

endpackage

// ==== rtl/sbac_fifo.sv ====
`timescale 1ns/1ps
module sbac_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_q [0:DEPTH-1];
  logic [PW:0] wr_q;
  logic [PW:0] wr_d;
  logic [PW:0] rd_q;
  logic [PW:0] rd_d;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = wr_q == rd_q;
  assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = buf_q[rd_q[PW-1:0]];
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      buf_q[wr_q[PW-1:0]] <= i_in_data;
    end
  end
endmodule

// ==== rtl/sbac_core.sv ====
`timescale 1ns/1ps
module sbac_core (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Command pins
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [sbac_pkg::BA_W-1:0] i_ba,
  input wire logic [sbac_pkg::ROW_W-1:0] i_addr,
  // Data pins
  input wire logic [sbac_pkg::BYTES-1:0] i_dqm,
  input wire logic [sbac_pkg::DATA_W-1:0] i_dq,
  output logic [sbac_pkg::DATA_W-1:0] o_dq,
  output logic [sbac_pkg::BYTES-1:0] o_dq_oe,
  // Status
  output logic o_power_down,
  output logic [sbac_pkg::REF_W-1:0] o_refresh_row
);
  function automatic sbac_pkg::sbac_cmd_t decode(sbac_pkg::sbac_pins_t p);
    sbac_pkg::sbac_cmd_t c;
    c = sbac_pkg::CMD_NOP;
    if (!p.cs_n) begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        sbac_pkg::PAT_MODE: c = sbac_pkg::CMD_MODE;
        sbac_pkg::PAT_REF: c = sbac_pkg::CMD_REF;
        sbac_pkg::PAT_PRE: c = sbac_pkg::CMD_PRE;
        sbac_pkg::PAT_ACT: c = sbac_pkg::CMD_ACT;
        sbac_pkg::PAT_WR: c = sbac_pkg::CMD_WRITE;
        sbac_pkg::PAT_RD: c = sbac_pkg::CMD_READ;
        sbac_pkg::PAT_TERM: c = sbac_pkg::CMD_TERM;
        default: c = sbac_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [sbac_pkg::BLEN_W-1:0] blen(logic [2:0] code);
    logic [sbac_pkg::BLEN_W-1:0] n;
    n = 9'h001;
    unique case (code)
      sbac_pkg::BL_2: n = 9'h002;
      sbac_pkg::BL_4: n = 9'h004;
      sbac_pkg::BL_8: n = 9'h008;
      sbac_pkg::BL_FULL: n = 9'h100;
      default: n = 9'h001;
    endcase
    return n;
  endfunction

  // Column for step idx of a burst, wrapping inside its block
  function automatic logic [sbac_pkg::COL_W-1:0] burst_col(
    logic [sbac_pkg::COL_W-1:0] start,
    logic [sbac_pkg::BLEN_W-1:0] idx,
    sbac_pkg::sbac_mode_t m
  );
    logic [sbac_pkg::BLEN_W-1:0] l;
    logic [sbac_pkg::COL_W-1:0] mask;
    logic [sbac_pkg::COL_W-1:0] off;
    l = blen(m.burst_length_setting) - 9'h001;
    mask = l[sbac_pkg::COL_W-1:0];
    off = m.interleaved ? (start ^ idx[sbac_pkg::COL_W-1:0])
                        : start + idx[sbac_pkg::COL_W-1:0];
    return (start & ~mask) | (off & mask);
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic cke_q;
  logic en;
  sbac_pkg::sbac_pins_t pins;
  sbac_pkg::sbac_cmd_t cmd;
  sbac_pkg::sbac_mode_t mode_q;
  sbac_pkg::sbac_mode_t mode_d;
  logic [sbac_pkg::BANKS-1:0] open_q;
  logic [sbac_pkg::BANKS-1:0] open_d;
  logic [sbac_pkg::BANKS-1:0][sbac_pkg::ROW_W-1:0] row_q;
  logic [sbac_pkg::BANKS-1:0][sbac_pkg::ROW_W-1:0] row_d;
  sbac_pkg::sbac_burst_t burst_q;
  sbac_pkg::sbac_burst_t burst_d;
  sbac_pkg::sbac_burst_t cur;
  logic [sbac_pkg::REF_W-1:0] ref_q;
  logic [sbac_pkg::REF_W-1:0] ref_d;
  logic pd_q;
  logic pd_d;
  logic new_acc;
  logic iss;
  logic stall;
  logic last;
  logic [sbac_pkg::COL_W-1:0] iss_col;
  logic [sbac_pkg::ADDR_W-1:0] iss_idx;
  logic [sbac_pkg::DATA_W-1:0] mem_q [0:sbac_pkg::MEM_WORDS-1];
  logic fill_valid;
  logic fill_ready;
  logic drain_valid;
  logic drain_ready;
  logic [sbac_pkg::DATA_W-1:0] drain_data;
  logic [sbac_pkg::LAT_STAGES-1:0] mark_q;
  logic [sbac_pkg::LAT_STAGES-1:0] mark_d;
  logic [1:0] lat_sel;
  logic [sbac_pkg::BYTES-1:0] dqm_q;
  logic [sbac_pkg::BYTES-1:0] dqm_d;
  logic [sbac_pkg::DATA_W-1:0] dq_q;
  logic [sbac_pkg::DATA_W-1:0] dq_d;
  logic [sbac_pkg::BYTES-1:0] oe_q;
  logic [sbac_pkg::BYTES-1:0] oe_d;

  // Reset release through two flops
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Low clock enable at one edge freezes the core at the next
  assign en = cke_q;
  assign pins = '{i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr};
  assign cmd = en ? decode(pins) : sbac_pkg::CMD_NOP;
  assign new_acc = (cmd == sbac_pkg::CMD_READ || cmd == sbac_pkg::CMD_WRITE)
                   && open_q[i_ba];

  always_comb begin
    mode_d = mode_q;
    open_d = open_q;
    row_d = row_q;
    ref_d = ref_q;
    cur = burst_q;
    unique case (cmd)
      sbac_pkg::CMD_MODE: begin
        if (open_q == '0 && !burst_q.act) begin
          mode_d.burst_length_setting =
            i_addr[sbac_pkg::MR_BL_LSB +: 3];
          mode_d.interleaved = i_addr[sbac_pkg::MR_BT_BIT];
          mode_d.cl = i_addr[sbac_pkg::MR_CL_LSB +: 3];
          mode_d.single_write = i_addr[sbac_pkg::MR_WB_BIT];
        end
      end
      sbac_pkg::CMD_ACT: begin
        if (!open_q[i_ba]) begin
          open_d[i_ba] = 1'b1;
          row_d[i_ba] = i_addr;
        end
      end
      sbac_pkg::CMD_PRE: begin
        if (i_addr[sbac_pkg::AP_BIT]) begin
          open_d = '0;
        end else begin
          open_d[i_ba] = 1'b0;
        end
      end
      sbac_pkg::CMD_REF: begin
        if (open_q == '0 && !burst_q.act) begin
          ref_d = ref_q + 1'b1;
        end
      end
      default: ;
    endcase
    if (new_acc) begin
      // Auto precharge burst cut by a new read or write still closes its bank
      if (burst_q.act && burst_q.ap) begin
        open_d[burst_q.ba] = 1'b0;
      end
      cur.act = 1'b1;
      cur.wr = cmd == sbac_pkg::CMD_WRITE;
      cur.ap = i_addr[sbac_pkg::AP_BIT];
      cur.ba = i_ba;
      cur.start = i_addr[sbac_pkg::COL_W-1:0];
      cur.idx = '0;
    end else if (cmd == sbac_pkg::CMD_TERM) begin
      cur.act = 1'b0;
    end else if (cmd == sbac_pkg::CMD_PRE &&
                 (i_addr[sbac_pkg::AP_BIT] || i_ba == burst_q.ba)) begin
      cur.act = 1'b0;
    end
    iss_col = burst_col(cur.start, cur.idx, mode_q);
    iss_idx = {cur.ba, row_q[cur.ba], iss_col};
    // Full buffer holds the burst rather than drop read data
    stall = en && cur.act && !cur.wr && !fill_ready;
    iss = en && cur.act && !stall;
    last = (cur.idx == blen(mode_q.burst_length_setting) - 9'h001)
           || (cur.wr && mode_q.single_write);
    burst_d = burst_q;
    if (iss) begin
      burst_d = cur;
      if (last) begin
        burst_d.act = 1'b0;
        if (cur.ap) begin
          open_d[cur.ba] = 1'b0;
        end
      end else begin
        burst_d.idx = cur.idx + 1'b1;
      end
    end else if (en && !stall) begin
      burst_d = cur;
    end
    pd_d = !i_cke && !burst_q.act && mark_q == '0;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_q <= 1'b1;
      mode_q <= sbac_pkg::MODE_RESET;
      open_q <= '0;
      row_q <= '0;
      burst_q <= '0;
      ref_q <= '0;
      pd_q <= 1'b0;
    end else begin
      cke_q <= i_cke;
      mode_q <= mode_d;
      open_q <= open_d;
      row_q <= row_d;
      burst_q <= burst_d;
      ref_q <= ref_d;
      pd_q <= pd_d;
    end
  end

  // Storage array with byte-masked writes
  always_ff @(posedge i_sys_clk) begin
    if (iss && cur.wr) begin
      for (int b = 0; b < sbac_pkg::BYTES; b++) begin
        if (!i_dqm[b]) begin
          mem_q[iss_idx][8*b +: 8] <= i_dq[8*b +: 8];
        end
      end
    end
  end

  // Read words queue here until their latency slot comes up
  assign fill_valid = iss && !cur.wr;

  sbac_fifo #(
    .WIDTH(sbac_pkg::DATA_W),
    .DEPTH(sbac_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_in_valid(fill_valid),
    .o_in_ready(fill_ready),
    .i_in_data(mem_q[iss_idx]),
    .o_out_valid(drain_valid),
    .i_out_ready(drain_ready),
    .o_out_data(drain_data)
  );

  always_comb begin
    unique case (mode_q.cl)
      sbac_pkg::CL_1: lat_sel = 2'h0;
      sbac_pkg::CL_2: lat_sel = 2'h1;
      default: lat_sel = 2'h2;
    endcase
    drain_ready = en && mark_q[lat_sel];
    mark_d = en ? {mark_q[sbac_pkg::LAT_STAGES-2:0], fill_valid} : mark_q;
    dqm_d = en ? i_dqm : dqm_q;
    dq_d = dq_q;
    oe_d = oe_q;
    if (en) begin
      oe_d = '0;
      if (drain_ready && drain_valid) begin
        dq_d = drain_data;
        oe_d = ~dqm_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_q <= '0;
      dqm_q <= '0;
      dq_q <= '0;
      oe_q <= '0;
    end else begin
      mark_q <= mark_d;
      dqm_q <= dqm_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
    end
  end

  assign o_dq = dq_q;
  assign o_dq_oe = oe_q;
  assign o_power_down = pd_q;
  assign o_refresh_row = ref_q;

  act_opens_row_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (cmd == sbac_pkg::CMD_ACT && !open_q[i_ba])
      |=> open_q[$past(i_ba)] && row_q[$past(i_ba)] == $past(i_addr)
  ) else $error("activate did not open the addressed row");

  suspend_freeze_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    !en |=> open_q == $past(open_q) && burst_q == $past(burst_q)
  ) else $error("state moved while clock enable was low");

  start_col_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (new_acc && iss) |-> iss_col == i_addr[sbac_pkg::COL_W-1:0]
  ) else $error("burst did not start at the given column");

  burst_step_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (iss && !last) |=> burst_q.act && burst_q.idx == $past(cur.idx) + 1'b1
  ) else $error("burst step did not advance");

  burst_end_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (iss && last && !new_acc) ##1 !new_acc |-> !burst_q.act
  ) else $error("burst ran past its length");

  auto_close_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (iss && last && cur.ap && cmd != sbac_pkg::CMD_ACT)
      |=> !open_q[$past(cur.ba)]
  ) else $error("auto precharge left the row open");

  every_cycle_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (new_acc && fill_ready) |-> iss
  ) else $error("column command not accepted");

  other_bank_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (cmd == sbac_pkg::CMD_PRE && !i_addr[sbac_pkg::AP_BIT] && iss
     && !last && !new_acc && i_ba != burst_q.ba) |=> burst_q.act
  ) else $error("precharge of other bank broke the burst");

  refresh_step_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (cmd == sbac_pkg::CMD_REF && open_q == '0 && !burst_q.act)
      |=> ref_q == $past(ref_q) + 1'b1
  ) else $error("refresh did not advance the row");

  store_word_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (iss && cur.wr && i_dqm == '0) |=> mem_q[$past(iss_idx)] == $past(i_dq)
  ) else $error("written word not stored");
endmodule

// ==== sim/sbac_ctrl_model.sv ====
`timescale 1ns/1ps
module sbac_ctrl_model (
  // Clock
  input wire logic i_sys_clk,
  // Pins toward the device
  output sbac_pkg::sbac_pins_t o_pins,
  output logic o_cke,
  output logic [sbac_pkg::BYTES-1:0] o_dqm,
  output logic [sbac_pkg::DATA_W-1:0] o_dq
);
  initial begin
    o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 11'h000};
    o_cke = 1'b1;
    o_dqm = 4'h0;
    o_dq = 32'h0000_0000;
  end

  // Pins move 1 ns after an edge and hold across the next one
  task automatic cmd(input logic [2:0] pat, input logic [1:0] ba = 2'h0,
      input logic [10:0] a = 11'h000, input logic [31:0] d = 32'h0,
      input logic [3:0] m = 4'h0);
    @(posedge i_sys_clk);
    #1;
    o_pins = '{1'b0, pat[2], pat[1], pat[0], ba, a};
    o_dq = d;
    o_dqm = m;
  endtask

  // Idle lines flip so a stale value is never mistaken for a fresh one
  task automatic idle(input int n);
    repeat (n) cmd(3'h7, ~o_pins.ba, ~o_pins.addr, ~o_dq);
  endtask

  // Chip select high: the pattern on the other pins must be ignored
  task automatic inhibit(input logic [2:0] pat);
    @(posedge i_sys_clk);
    #1;
    o_pins = '{1'b1, pat[2], pat[1], pat[0], 2'h0, 11'h000};
  endtask

  // Close the bank before opening a row in it
  task automatic act(input logic [1:0] ba, input logic [10:0] row);
    cmd(sbac_pkg::PAT_PRE, ba, 11'h000);
    cmd(sbac_pkg::PAT_ACT, ba, row);
  endtask

  // Clock enable drops only with the core idle, never for self refresh
  task automatic cke_set(input logic v);
    @(posedge i_sys_clk);
    #1;
    o_cke = v;
  endtask
endmodule

// ==== sim/tb_sdram_bank_access_core.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module tb_sdram_bank_access_core;
  typedef struct packed {
    logic [2:0] bl;
    logic il;
    logic [7:0] s;
    logic [8:0] n;
  } sbac_row_t;
  logic clk;
  logic rst_n;
  sbac_pkg::sbac_pins_t pins;
  logic cke;
  logic [3:0] dqm;
  logic [31:0] dq;
  logic [31:0] o_dq;
  logic [3:0] o_dq_oe;
  logic o_power_down;
  logic [11:0] o_refresh_row;
  logic [31:0] rd_q[$];
  logic [31:0] exp_q[$];
  int errors = 0;
  int checks = 0;
  sbac_row_t rows[6] = '{'{sbac_pkg::BL_1, 1'b0, 8'h06, 9'h001},
    '{sbac_pkg::BL_2, 1'b0, 8'h07, 9'h002},
    '{sbac_pkg::BL_4, 1'b0, 8'h06, 9'h004},
    '{sbac_pkg::BL_8, 1'b0, 8'h03, 9'h008},
    '{sbac_pkg::BL_4, 1'b1, 8'h05, 9'h004},
    '{sbac_pkg::BL_8, 1'b1, 8'h02, 9'h008}};

  sbac_ctrl_model u_ctl (.i_sys_clk(clk), .o_pins(pins), .o_cke(cke),
    .o_dqm(dqm), .o_dq(dq));
  sbac_core DUT (.i_sys_clk(clk), .i_resetn(rst_n), .i_cke(cke),
    .i_cs_n(pins.cs_n), .i_ras_n(pins.ras_n), .i_cas_n(pins.cas_n),
    .i_we_n(pins.we_n), .i_ba(pins.ba), .i_addr(pins.addr), .i_dqm(dqm),
    .i_dq(dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_power_down(o_power_down), .o_refresh_row(o_refresh_row));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Words are taken once the edge's updates have landed
  always @(posedge clk) begin
    #2;
    if (o_dq_oe !== 4'h0) rd_q.push_back(o_dq);
  end

  function automatic logic [31:0] dat(input int c);
    return 32'hC0DE_0000 + 32'(c);
  endfunction

  function automatic logic [10:0] mr(input logic [2:0] bl, input logic il);
    return {4'h0, sbac_pkg::CL_2, il, bl};
  endfunction

  task automatic issue(input logic [2:0] p, input logic [1:0] b,
      input logic [10:0] a);
    rd_q = {};
    u_ctl.cmd(p, b, a);
  endtask

  task automatic check_words;
    u_ctl.idle(12);
    `CHK("word count", exp_q.size(), rd_q.size())
    for (int i = 0; i < exp_q.size() && i < rd_q.size(); i++)
      `CHK("read word", exp_q[i], rd_q[i])
    exp_q = {};
  endtask

  task automatic set_mode(input logic [2:0] bl, input logic il);
    u_ctl.cmd(sbac_pkg::PAT_PRE, 2'h0, 11'h400);
    u_ctl.cmd(sbac_pkg::PAT_MODE, 2'h0, mr(bl, il));
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    int m;
    int s;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    u_ctl.idle(4);
    `CHK("oe reset", 4'h0, o_dq_oe)
    `CHK("pd reset", 1'b0, o_power_down)
    u_ctl.cmd(sbac_pkg::PAT_REF);
    u_ctl.cmd(sbac_pkg::PAT_REF);
    u_ctl.idle(2);
    `CHK("refresh count", 12'h002, o_refresh_row)
    set_mode(sbac_pkg::BL_1, 1'b0);
    u_ctl.act(2'h0, 11'h005);
    for (int c = 0; c < 16; c++)
      u_ctl.cmd(sbac_pkg::PAT_WR, 2'h0, 11'(c), dat(c));
    issue(sbac_pkg::PAT_RD, 2'h0, 11'h009);
    u_ctl.cmd(sbac_pkg::PAT_RD, 2'h0, 11'h002);
    u_ctl.cmd(sbac_pkg::PAT_RD, 2'h0, 11'h00E);
    exp_q = '{dat(9), dat(2), dat(14)};
    check_words();
    // Ordinary bursts: length, order and wrap inside the block
    for (int r = 0; r < 6; r++) begin
      set_mode(rows[r].bl, rows[r].il);
      u_ctl.act(2'h0, 11'h005);
      m = int'(rows[r].n) - 1;
      s = int'(rows[r].s);
      for (int i = 0; i < rows[r].n; i++)
        exp_q.push_back(dat(rows[r].il ? (s ^ i) : ((s & ~m) | ((s + i) & m))));
      issue(sbac_pkg::PAT_RD, 2'h0, {3'h0, rows[r].s});
      check_words();
    end
    // Write burst with the low bytes masked on its second word
    set_mode(sbac_pkg::BL_2, 1'b0);
    u_ctl.act(2'h0, 11'h005);
    u_ctl.cmd(sbac_pkg::PAT_WR, 2'h0, 11'h009, 32'h1111_1111);
    u_ctl.cmd(3'h7, 2'h0, 11'h000, 32'h2222_2222, 4'h3);
    exp_q = '{32'h1111_1111, 32'h2222_0008};
    issue(sbac_pkg::PAT_RD, 2'h0, 11'h009);
    check_words();
    issue(sbac_pkg::PAT_RD, 2'h0, 11'h400);
    exp_q = '{dat(0), dat(1)};
    check_words();
    issue(sbac_pkg::PAT_RD, 2'h0, 11'h000);
    check_words();
    // Full row burst cut after three words
    set_mode(sbac_pkg::BL_FULL, 1'b0);
    u_ctl.act(2'h0, 11'h005);
    issue(sbac_pkg::PAT_RD, 2'h0, 11'h000);
    u_ctl.idle(2);
    u_ctl.cmd(sbac_pkg::PAT_TERM);
    exp_q = '{dat(0), dat(1), dat(2)};
    check_words();
    // Bank 0 closed while bank 1 bursts
    set_mode(sbac_pkg::BL_8, 1'b0);
    u_ctl.act(2'h1, 11'h007);
    u_ctl.cmd(sbac_pkg::PAT_WR, 2'h1, 11'h000, 32'hBEEF_0000);
    for (int i = 1; i < 8; i++) u_ctl.cmd(3'h7, 2'h1, 11'h000, dat(i) ^ 32'h7E31_0000);
    u_ctl.act(2'h0, 11'h005);
    issue(sbac_pkg::PAT_RD, 2'h1, 11'h000);
    u_ctl.cmd(sbac_pkg::PAT_PRE, 2'h0, 11'h000);
    exp_q.push_back(32'hBEEF_0000);
    for (int i = 1; i < 8; i++) exp_q.push_back(dat(i) ^ 32'h7E31_0000);
    check_words();
    issue(sbac_pkg::PAT_RD, 2'h0, 11'h003);
    check_words();
    // Deselected read on an open bank gives no words
    u_ctl.act(2'h0, 11'h005);
    rd_q = {};
    u_ctl.inhibit(sbac_pkg::PAT_RD);
    check_words();
    // Reset in mid-run clears the refresh count and the drivers
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    u_ctl.idle(3);
    `CHK("refresh reset", 12'h000, o_refresh_row)
    `CHK("oe mid reset", 4'h0, o_dq_oe)
    u_ctl.cke_set(1'b0);
    repeat (3) @(posedge clk);
    #2 `CHK("power down", 1'b1, o_power_down)
    u_ctl.cke_set(1'b1);
    u_ctl.idle(3);
    `CHK("power up", 1'b0, o_power_down)
    end_of_test();
  end
endmodule
